/* File: rtl/bgp_map.svh */
`ifndef BGP_MAP_SVH
`define BGP_MAP_SVH

// register word indices of the controller's own port
`define BGP_REG_CTRL 4'h0
`define BGP_REG_TIMING 4'h1
`define BGP_REG_STATUS 4'h2
`define BGP_REG_IRQ_STAT 4'h3
`define BGP_REG_IRQ_MASK 4'h4
`define BGP_REG_PERIOD 4'h5
`define BGP_REG_DEMAND 4'h6

// ctrl field positions
`define BGP_CTRL_EN 0
`define BGP_CTRL_SRC 1
`define BGP_CTRL_INV 2
`define BGP_CTRL_GAIN_LO 3
`define BGP_CTRL_MULTI_LO 5
`define BGP_CTRL_OVSD_LO 7

// timing field positions
`define BGP_TIM_TON_LO 0
`define BGP_TIM_TOFF_LO 2
`define BGP_TIM_SKIP_LO 4

// interrupt bits
`define BGP_IRQ_OV 0
`define BGP_IRQ_STOP 1

// reset values
`define BGP_CTRL_RST 10'h000
`define BGP_TIMING_RST 6'h00
`define BGP_PERIOD_RST 12'h000

// sync debounce, in clock cycles
`define BGP_SYNC_DEBOUNCE 2

`endif

/* File: rtl/bgp_pkg.sv */
package bgp_pkg;
    typedef enum logic [1:0] {
        BGP_IDLE,
        BGP_ON,
        BGP_OFF
    } bgp_gate_e;

    typedef struct packed {
        logic [2:0] ov_offset;
        logic [1:0] multi_mode;
        logic [1:0] amp_gain;
        logic edge_inv;
        logic src_ext;
        logic enable;
    } bgp_cfg_s;
endpackage

/* File: rtl/bgp_link_if.sv */
`timescale 1ns/1ps
interface bgp_link_if;
    logic phase_sync_input;
    bgp_pkg::bgp_cfg_s cfg;
    logic [1:0] gate_min_on_time_sel;
    logic [1:0] gate_min_off_time_sel;
    logic [1:0] light_load_skip_sel;
    logic overvoltage_flag;
    logic booster_running;
    logic ov_flag_read;

    modport dev
    (
        input phase_sync_input,
        input cfg,
        input gate_min_on_time_sel,
        input gate_min_off_time_sel,
        input light_load_skip_sel,
        input ov_flag_read,
        output overvoltage_flag,
        output booster_running
    );

    modport ctl
    (
        output phase_sync_input,
        output cfg,
        output gate_min_on_time_sel,
        output gate_min_off_time_sel,
        output light_load_skip_sel,
        output ov_flag_read,
        input overvoltage_flag,
        input booster_running
    );
endinterface

/* File: rtl/bgp_sync_edge.sv */
`timescale 1ns/1ps
`include "bgp_map.svh"
// two-stage sampler, debounce and selectable edge pulse
module bgp_sync_edge
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sync_in,
    input wire logic edge_inv,
    output logic edge_pulse
);
    logic meta_ff;
    logic samp_ff;
    logic [1:0] hist_ff;
    logic stable_ff;
    logic nxt_stable;
    wire agree = (hist_ff[0] == samp_ff) && (hist_ff[1] == samp_ff);

    // level accepted only after stable for the debounce window
    assign nxt_stable = agree ? samp_ff : stable_ff;

    // sampling and debounce
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_ff <= 1'b0;
            samp_ff <= 1'b0;
            hist_ff <= 2'h0;
            stable_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= sync_in;
            samp_ff <= meta_ff;
            hist_ff <= {hist_ff[0], samp_ff};
            stable_ff <= nxt_stable;
        end
    end

    // rising edge by default, falling when inverted
    assign edge_pulse = (nxt_stable != stable_ff) && (nxt_stable == ~edge_inv);
endmodule

/* File: rtl/bgp_booster.sv */
`timescale 1ns/1ps
`include "bgp_map.svh"
module bgp_booster #(
    parameter int PER_W = 12,
    parameter int COMP_W = 8,
    parameter logic [11:0] INT_PERIOD = 12'h271
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    bgp_link_if.dev link,
    input wire logic [COMP_W-1:0] compensation_voltage,
    input wire logic [PER_W-1:0] demand_on_cycles,
    input wire logic ov_above_shutdown,
    input wire logic ov_below_react,
    output logic gate_drive,
    output logic [PER_W-1:0] period_cycles
);
    bgp_pkg::bgp_gate_e state_ff, nxt_state;
    logic [PER_W-1:0] cnt_ff;
    logic [PER_W-1:0] int_cnt_ff;
    logic [PER_W-1:0] on_len_ff;
    logic [PER_W-1:0] last_per_ff;
    logic ov_ff;
    logic ov_lock_ff;
    logic [PER_W-1:0] nxt_on_len;
    logic ext_edge;

    // minimum on/off table in system clock cycles
    function automatic logic [PER_W-1:0] min_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: min_cycles = PER_W'(8);
            2'h1: min_cycles = PER_W'(16);
            2'h2: min_cycles = PER_W'(32);
            default: min_cycles = PER_W'(64);
        endcase
    endfunction

    // compensation threshold per skip code
    function automatic logic [COMP_W-1:0] skip_thr(input logic [1:0] sel);
        case (sel)
            2'h1: skip_thr = COMP_W'(32);
            2'h2: skip_thr = COMP_W'(48);
            default: skip_thr = COMP_W'(64);
        endcase
    endfunction

    bgp_sync_edge u_sync
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .sync_in(link.phase_sync_input),
        .edge_inv(link.cfg.edge_inv),
        .edge_pulse(ext_edge)
    );

    wire enabled = link.cfg.enable;
    wire int_wrap = (int_cnt_ff >= INT_PERIOD - 12'h001);
    wire period_start = enabled && (link.cfg.src_ext ? ext_edge : int_wrap);
    wire [PER_W-1:0] ton_min = min_cycles(link.gate_min_on_time_sel);
    wire [PER_W-1:0] toff_min = min_cycles(link.gate_min_off_time_sel);
    wire [PER_W-1:0] ref_per = link.cfg.src_ext ? last_per_ff : INT_PERIOD;
    wire [PER_W-1:0] max_on = (ref_per > toff_min) ? ref_per - toff_min : '0;
    wire skip_active = (link.light_load_skip_sel != 2'h0);
    wire skip_now = skip_active &&
        (compensation_voltage < skip_thr(link.light_load_skip_sel));
    wire blocked = ov_lock_ff || ov_above_shutdown || !enabled;
    wire [PER_W-1:0] want_on = (demand_on_cycles < ton_min) ? ton_min : demand_on_cycles;

    always_comb
    begin
        if (demand_on_cycles == '0 || skip_now || blocked)
            nxt_on_len = '0;
        else if (want_on > max_on)
            nxt_on_len = max_on;
        else
            nxt_on_len = want_on;
    end

    // gate state machine
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            bgp_pkg::BGP_IDLE:
                if (period_start && nxt_on_len != '0)
                    nxt_state = bgp_pkg::BGP_ON;
            bgp_pkg::BGP_ON:
                if (blocked)
                    nxt_state = bgp_pkg::BGP_IDLE;
                else if (cnt_ff + PER_W'(1) >= on_len_ff)
                    nxt_state = bgp_pkg::BGP_OFF;
            bgp_pkg::BGP_OFF:
                if (period_start && nxt_on_len != '0)
                    nxt_state = bgp_pkg::BGP_ON;
            default: nxt_state = bgp_pkg::BGP_IDLE;
        endcase
    end

    // counters and state
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= bgp_pkg::BGP_IDLE;
            cnt_ff <= '0;
            int_cnt_ff <= '0;
            on_len_ff <= '0;
            last_per_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            int_cnt_ff <= (!enabled || int_wrap) ? '0 : int_cnt_ff + PER_W'(1);
            cnt_ff <= period_start ? '0 : cnt_ff + PER_W'(1);
            if (period_start)
            begin
                on_len_ff <= nxt_on_len;
                last_per_ff <= cnt_ff + PER_W'(1);
            end
        end
    end

    // over-voltage latch and lockout, set wins over read
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ov_ff <= 1'b0;
            ov_lock_ff <= 1'b0;
        end
        else
        begin
            ov_ff <= ov_above_shutdown | (ov_ff & ~link.ov_flag_read);
            if (ov_above_shutdown)
                ov_lock_ff <= 1'b1;
            else if (ov_below_react)
                ov_lock_ff <= 1'b0;
        end
    end

    // gate only while on and enabled
    assign gate_drive = (state_ff == bgp_pkg::BGP_ON) && enabled && !ov_lock_ff;
    assign link.overvoltage_flag = ov_ff;
    assign link.booster_running = enabled && !ov_lock_ff;
    assign period_cycles = last_per_ff;
endmodule

/* File: rtl/bgp_ctrl.sv */
`timescale 1ns/1ps
`include "bgp_map.svh"
// controller end: sync clock generator and configuration registers
module bgp_ctrl
(
    input wire logic mclk,
    input wire logic sys_rst,
    bgp_link_if.ctl link,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    logic [9:0] ctrl_ff;
    logic [5:0] tim_ff;
    logic [11:0] per_ff;
    logic [11:0] cnt_ff;
    logic sync_ff;
    logic [1:0] ist_ff;
    logic [1:0] imask_ff;
    logic ov_prev_ff;
    logic run_prev_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_mux;

    wire wr_ctrl = wr && addr == `BGP_REG_CTRL;
    wire rd_ist = rd && addr == `BGP_REG_IRQ_STAT;
    wire rd_stat = rd && addr == `BGP_REG_STATUS;
    wire ev_ov = link.overvoltage_flag && !ov_prev_ff;
    wire ev_stop = run_prev_ff && !link.booster_running;
    wire [10:0] half = per_ff[11:1];

    // read select
    always_comb
    begin
        case (addr)
            `BGP_REG_CTRL: rd_mux = {22'h0, ctrl_ff};
            `BGP_REG_TIMING: rd_mux = {26'h0, tim_ff};
            `BGP_REG_STATUS: rd_mux = {30'h0, link.booster_running, link.overvoltage_flag};
            `BGP_REG_IRQ_STAT: rd_mux = {30'h0, ist_ff};
            `BGP_REG_IRQ_MASK: rd_mux = {30'h0, imask_ff};
            `BGP_REG_PERIOD: rd_mux = {20'h0, per_ff};
            default: rd_mux = 32'h0;
        endcase
    end

    // registers, sync generator, sticky events (set beats read clear)
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_ff <= `BGP_CTRL_RST;
            tim_ff <= `BGP_TIMING_RST;
            per_ff <= `BGP_PERIOD_RST;
            imask_ff <= 2'h0;
            ist_ff <= 2'h0;
            cnt_ff <= 12'h000;
            sync_ff <= 1'b0;
            ov_prev_ff <= 1'b0;
            run_prev_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= wdata[9:0];
            if (wr && addr == `BGP_REG_TIMING)
                tim_ff <= wdata[5:0];
            if (wr && addr == `BGP_REG_PERIOD)
                per_ff <= wdata[11:0];
            if (wr && addr == `BGP_REG_IRQ_MASK)
                imask_ff <= wdata[1:0];
            ist_ff <= {ev_stop, ev_ov} | (rd_ist ? 2'h0 : ist_ff);
            ov_prev_ff <= link.overvoltage_flag;
            run_prev_ff <= link.booster_running;
            if (rd)
                rdata_ff <= rd_mux;
            // one sync line, period from register
            if (per_ff == 12'h000 || cnt_ff >= per_ff - 12'h001)
                cnt_ff <= 12'h000;
            else
                cnt_ff <= cnt_ff + 12'h001;
            sync_ff <= (per_ff != 12'h000) && (cnt_ff < {1'b0, half});
        end
    end

    // configuration fields as programmed by software
    assign link.cfg = bgp_pkg::bgp_cfg_s'(ctrl_ff);
    assign link.gate_min_on_time_sel = tim_ff[1:0];
    assign link.gate_min_off_time_sel = tim_ff[3:2];
    assign link.light_load_skip_sel = tim_ff[5:4];
    assign link.phase_sync_input = sync_ff;
    // status read acknowledges the latched flag
    assign link.ov_flag_read = rd_stat;
    assign rdata = rdata_ff;
    assign irq = |(ist_ff & imask_ff);
endmodule

/* File: verif/bgp_assertions.sv */
`timescale 1ns/1ps
// concurrent checks on the link and the gate
module bgp_assertions
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire bgp_pkg::bgp_cfg_s cfg,
    input wire logic [1:0] gate_min_on_time_sel,
    input wire logic phase_sync_input,
    input wire logic overvoltage_flag,
    input wire logic booster_running,
    input wire logic ov_flag_read,
    input wire logic gate_drive,
    input wire logic ov_above_shutdown
);
    logic [7:0] run_ff;
    logic [7:0] nxt_run;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // length of the pulse in progress
    assign nxt_run = gate_drive ? run_ff + 8'h01 : 8'h00;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            run_ff <= 8'h00;
        else
            run_ff <= nxt_run;
    end
    en_gates_a: assert property ($rose(gate_drive) |-> $past(cfg.enable))
        else $error("gate rose while disabled");
    min_on_a: assert property ($fell(gate_drive) && cfg.enable && !ov_above_shutdown
        && !$past(ov_above_shutdown) |-> run_ff >= (8'h08 << gate_min_on_time_sel))
        else $error("gate pulse too short");
    ov_flag_a: assert property ($rose(ov_above_shutdown) |-> ##[0:3] overvoltage_flag)
        else $error("overvoltage not flagged");
    ov_gate_a: assert property (ov_above_shutdown [*3] |-> !gate_drive)
        else $error("gate on during overvoltage");
    ov_run_a: assert property (ov_above_shutdown [*3] |-> !booster_running)
        else $error("running during overvoltage");
    flag_clr_a: assert property (ov_flag_read && !ov_above_shutdown
        && !$past(ov_above_shutdown) |=> !overvoltage_flag)
        else $error("flag not cleared by read");
    sync_rise_a: assert property ($rose(gate_drive) && cfg.src_ext && !cfg.edge_inv
        && !$past(cfg.edge_inv, 8) && $past(cfg.src_ext, 8)
        |-> $past(phase_sync_input, 4) && !$past(phase_sync_input, 7))
        else $error("gate not aligned to rising sync");
    sync_fall_a: assert property ($rose(gate_drive) && cfg.src_ext && cfg.edge_inv
        && $past(cfg.edge_inv, 8) && $past(cfg.src_ext, 8)
        |-> !$past(phase_sync_input, 4) && $past(phase_sync_input, 7))
        else $error("gate not aligned to falling sync");
    // main scenarios reached
    inv_c: cover property ($rose(gate_drive) && cfg.edge_inv);
    ovclr_c: cover property ($fell(overvoltage_flag));
    stop_c: cover property ($fell(booster_running));
endmodule

/* File: verif/boost_gate_pwm_duty_and_phase_sync_tb.sv */
`timescale 1ns/1ps
`include "bgp_map.svh"
// controller and booster joined by the link
module boost_gate_pwm_duty_and_phase_sync_tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic [7:0] comp = 8'h00;
    logic [11:0] demand = 12'h000;
    logic ov_above = 1'b0;
    logic ov_below = 1'b1;
    logic gate;
    logic [11:0] per;
    int n_errors = 0;
    int samples_checked = 0;
    bgp_link_if link_if();
    bgp_ctrl bgp_ctrl_inst
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .link(link_if),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .irq(irq)
    );
    bgp_booster bgp_booster_inst
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .link(link_if),
        .compensation_voltage(comp),
        .demand_on_cycles(demand),
        .ov_above_shutdown(ov_above),
        .ov_below_react(ov_below),
        .gate_drive(gate),
        .period_cycles(per)
    );
    bgp_assertions bgp_assertions_inst
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cfg(link_if.cfg),
        .gate_min_on_time_sel(link_if.gate_min_on_time_sel),
        .phase_sync_input(link_if.phase_sync_input),
        .overvoltage_flag(link_if.overvoltage_flag),
        .booster_running(link_if.booster_running),
        .ov_flag_read(link_if.ov_flag_read),
        .gate_drive(gate),
        .ov_above_shutdown(ov_above)
    );
    // free running clock
    initial
    begin
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // one read, data compared in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask
    // length of the first whole gate pulse after 250 cycles, 0 if none starts within 700 more
    task automatic pulse(input logic [31:0] e);
        int t;
        int n;
        t = 0;
        n = 0;
        repeat (250) @(negedge mclk);
        while (gate === 1'b1) @(negedge mclk);
        while (gate !== 1'b1 && t < 700)
        begin
            @(negedge mclk);
            t++;
        end
        while (gate === 1'b1)
        begin
            @(negedge mclk);
            n++;
        end
        chk("gate_on", e, 32'(n));
        @(posedge mclk);
    endtask
    // hang guard
    initial
    begin
        #400000;
        n_errors++;
        print_verdict;
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        reg_rd(`BGP_REG_CTRL, 32'h0);
        reg_rd(`BGP_REG_TIMING, 32'h0);
        reg_wr(4'hf, 32'hffff_ffff);
        reg_rd(4'hf, 32'h0);
        reg_wr(`BGP_REG_CTRL, 32'h0000_03f8);
        reg_rd(`BGP_REG_CTRL, 32'h0000_03f8);
        reg_wr(`BGP_REG_PERIOD, 32'h0000_00c8);
        reg_wr(`BGP_REG_CTRL, 32'h3);
        demand <= 12'h001;
        for (int c = 0; c < 4; c++)
        begin
            reg_wr(`BGP_REG_TIMING, 32'(c));
            pulse(32'h8 << c);
        end
        chk("period", 32'h0000_00c8, 32'(per));
        demand <= 12'h0c7;
        for (int c = 0; c < 4; c++)
        begin
            reg_wr(`BGP_REG_TIMING, 32'(c) << 2);
            pulse(32'hc8 - (32'h8 << c));
        end
        demand <= 12'h000;
        pulse(32'h0);
        demand <= 12'h001;
        pulse(32'h8);
        for (int c = 1; c < 4; c++)
        begin
            reg_wr(`BGP_REG_TIMING, 32'(c) << 4);
            comp <= 8'(16 + 16 * c) - 8'h01;
            pulse(32'h0);
            comp <= 8'(16 + 16 * c);
            pulse(32'h8);
        end
        reg_wr(`BGP_REG_TIMING, 32'h0);
        reg_wr(`BGP_REG_CTRL, 32'h7);
        pulse(32'h8);
        reg_wr(`BGP_REG_CTRL, 32'h6);
        pulse(32'h0);
        reg_wr(`BGP_REG_CTRL, 32'h3);
        ov_above <= 1'b1;
        ov_below <= 1'b0;
        pulse(32'h0);
        chk("irq", 32'h0, 32'(irq));
        reg_wr(`BGP_REG_IRQ_MASK, 32'h1);
        repeat (2) @(negedge mclk);
        chk("irq", 32'h1, 32'(irq));
        reg_rd(`BGP_REG_STATUS, 32'h1);
        reg_rd(`BGP_REG_IRQ_STAT, 32'h3);
        repeat (2) @(negedge mclk);
        chk("irq", 32'h0, 32'(irq));
        @(posedge mclk);
        ov_above <= 1'b0;
        ov_below <= 1'b1;
        pulse(32'h8);
        reg_rd(`BGP_REG_STATUS, 32'h3);
        reg_rd(`BGP_REG_STATUS, 32'h2);
        reg_wr(`BGP_REG_CTRL, 32'h1);
        pulse(32'h8);
        pulse(32'h8);
        chk("period", 32'h0000_0271, 32'(per));
        print_verdict;
    end
endmodule
